// file: bench/adc_halt_asserts.sv
// concurrent checks on the ports of the converter halt control block
`timescale 1ns/100ps
module adc_halt_asserts #(
  parameter int TIMEOUT_CYC = 50,
  parameter int START_CYC = 100
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_halt_strobe,
  input wire logic i_conversion_done_n,
  input wire logic i_level_we,
  input wire logic [7:0] i_level_data,
  input wire logic i_filter_we,
  input wire logic [7:0] i_filter_data,
  input wire logic o_convert_start,
  input wire logic o_processor_halt_n,
  input wire logic o_hold,
  input wire logic [7:0] o_attenuation,
  input wire logic [3:0] o_lowpass_sel,
  input wire logic [3:0] o_highpass_sel,
  input wire logic o_timeout,
  input wire logic o_ram_refresh_timing,
  input wire logic o_row_address_select,
  input wire logic o_row_strobe_timing,
  input wire logic o_column_strobe_timing
);
  logic [3:0] strobes;
  int st_cnt_r;
  int st_cnt_nxt;
  int to_cnt_r;
  int to_cnt_nxt;
  int up_cnt_r;
  int up_cnt_nxt;
  assign strobes = {o_ram_refresh_timing, o_row_address_select, o_row_strobe_timing,
    o_column_strobe_timing};
  always_comb
  begin
    st_cnt_nxt = o_convert_start ? st_cnt_r + 1 : 0;
    to_cnt_nxt = o_processor_halt_n ? 0 : to_cnt_r + 1;
    up_cnt_nxt = (up_cnt_r < 31) ? up_cnt_r + 1 : up_cnt_r;
  end
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      st_cnt_r <= 0;
      to_cnt_r <= 0;
      up_cnt_r <= 0;
    end
    else
    begin
      st_cnt_r <= st_cnt_nxt;
      to_cnt_r <= to_cnt_nxt;
      up_cnt_r <= up_cnt_nxt;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_strobe_idle;
    i_halt_strobe && o_processor_halt_n;
  endsequence
  sequence s_done_halted;
    !o_processor_halt_n && $fell(i_conversion_done_n);
  endsequence
  property p_halt;
    s_strobe_idle |-> ##[1:2] !o_processor_halt_n;
  endproperty
  AST_HALT: assert property (p_halt)
    else $error("halt strobe did not stop the processor");
  AST_RELEASE: assert property (s_done_halted |-> ##[2:5] o_processor_halt_n)
    else $error("conversion done did not release the halt");
  AST_START_LEN: assert property ($fell(o_convert_start) |-> st_cnt_r == START_CYC)
    else $error("start pulse length wrong");
  AST_HOLD_START: assert property (o_convert_start |-> o_hold)
    else $error("sample hold not set during start");
  AST_HOLD_END: assert property ($fell(i_conversion_done_n) && o_hold |-> ##[1:5] !o_hold)
    else $error("sample hold not freed after done");
  AST_TIMEOUT: assert property (to_cnt_r <= TIMEOUT_CYC + 2)
    else $error("halt held past the timeout");
  AST_TO_PULSE: assert property (o_timeout |=> !o_timeout)
    else $error("timeout flag longer than one cycle");
  AST_TO_REL: assert property (o_timeout |-> ##[0:1] o_processor_halt_n)
    else $error("timeout without release");
  AST_LEVEL: assert property (i_level_we |=> o_attenuation == $past(i_level_data))
    else $error("attenuation not loaded");
  AST_LP: assert property (i_filter_we |=> o_lowpass_sel == $past(i_filter_data[3:0]))
    else $error("lowpass select not loaded");
  AST_HP: assert property (!i_filter_we |=> $stable(o_highpass_sel))
    else $error("highpass select changed without write");
  AST_HP_LOAD: assert property (i_filter_we |=> o_highpass_sel == $past(i_filter_data[7:4]))
    else $error("highpass select not loaded");
  AST_TIMING: assert property (up_cnt_r == 31 |-> strobes == $past(strobes, 16))
    else $error("memory timing strobes not periodic");
endmodule // adc_halt_asserts

// file: bench/conv_model.sv
// behavioural model of the external converter chip
`timescale 1ns/100ps
module conv_model (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic i_fail,
  input wire logic i_slow,
  input wire logic [15:0] i_value,
  output logic o_done_n,
  output logic [15:0] o_data
);
  initial
  begin
    o_done_n = 1'b1;
    o_data = 16'h0000;
  end
  // a failed converter never reports done
  always @(posedge i_start)
  begin
    if (!i_fail)
    begin
      repeat (i_slow ? 300 : 110) @(posedge i_clk);
      #2 o_data = i_value;
      repeat (2) @(posedge i_clk);
      #2 o_done_n = 1'b0;
      repeat (8) @(posedge i_clk);
      #2 o_done_n = 1'b1;
      o_data = ~i_value;
    end
  end
endmodule // conv_model

// file: bench/tb_top.sv
// self-checking bench for the converter halt control block
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module tb_top;
  localparam int TO = 400;
  logic i_clk, i_reset, i_sample_clock, i_converter_mode, i_halt_strobe;
  logic i_conversion_done_n, i_level_we, i_filter_we, i_sample_ready;
  logic [7:0] i_level_data, i_filter_data, o_attenuation;
  logic [15:0] i_conv_data, o_sample_data, val;
  logic o_sample_valid, o_convert_start, o_processor_halt_n, o_hold, o_timeout;
  logic o_ram_refresh_timing, o_row_address_select, o_row_strobe_timing;
  logic o_column_strobe_timing, fail, slow, seen;
  logic [3:0] o_lowpass_sel, o_highpass_sel;
  logic [3:0] tstrobe, t_or, t_and;
  logic [31:0] rnd = 32'h00000A9E;
  logic [15:0] exp_q[$];
  int n_mismatch = 0;
  int checked = 0;
  int n;
  assign tstrobe = {o_ram_refresh_timing, o_row_address_select, o_row_strobe_timing,
    o_column_strobe_timing};
  adc_halt_control #(
    .TIMEOUT_CYC(TO)
  ) adc_halt_control_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_sample_clock(i_sample_clock),
    .i_converter_mode(i_converter_mode),
    .i_halt_strobe(i_halt_strobe),
    .i_conversion_done_n(i_conversion_done_n),
    .i_conv_data(i_conv_data),
    .i_level_we(i_level_we),
    .i_level_data(i_level_data),
    .i_filter_we(i_filter_we),
    .i_filter_data(i_filter_data),
    .i_sample_ready(i_sample_ready),
    .o_sample_valid(o_sample_valid),
    .o_sample_data(o_sample_data),
    .o_convert_start(o_convert_start),
    .o_processor_halt_n(o_processor_halt_n),
    .o_hold(o_hold),
    .o_attenuation(o_attenuation),
    .o_lowpass_sel(o_lowpass_sel),
    .o_highpass_sel(o_highpass_sel),
    .o_timeout(o_timeout),
    .o_ram_refresh_timing(o_ram_refresh_timing),
    .o_row_address_select(o_row_address_select),
    .o_row_strobe_timing(o_row_strobe_timing),
    .o_column_strobe_timing(o_column_strobe_timing)
  );
  conv_model conv_model_inst (.i_clk(i_clk), .i_start(o_convert_start), .i_fail(fail),
    .i_slow(slow), .i_value(val), .o_done_n(i_conversion_done_n), .o_data(i_conv_data));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task tick;
    @(posedge i_clk);
    #2;
  endtask
  task give_verdict;
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic conv(input logic f);
    rnd = xorshift(rnd);
    fail = f;
    slow = rnd[16];
    val = rnd[15:0];
    i_sample_clock = 1'b1;
    n = 0;
    while (o_convert_start !== 1'b1 && n < 10)
    begin
      tick();
      n++;
    end
    `CHK(o_convert_start, 1'b1)
    i_sample_clock = 1'b0;
    i_halt_strobe = 1'b1;
    tick();
    i_halt_strobe = 1'b0;
    tick();
    `CHK(o_processor_halt_n, 1'b0)
    n = 0;
    while (o_processor_halt_n !== 1'b1 && n < 600)
    begin
      tick();
      n++;
    end
    if (f)
      `CHK(n > TO - 8, 1'b1)
    else
      `CHK(n < TO, 1'b1)
    if (!f && exp_q.size() < 8)
      exp_q.push_back(val);
    repeat (12) tick();
  endtask
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    {i_sample_clock, i_converter_mode, i_halt_strobe, i_level_we, i_filter_we} = 5'h00;
    {i_sample_ready, fail, slow, seen} = 4'h0;
    t_or = 4'h0;
    t_and = 4'hF;
    {i_level_data, i_filter_data, val} = 32'h00000000;
    i_reset = 1'b1;
    repeat (3) @(posedge i_clk);
    #2 i_reset = 1'b0;
    `CHK(o_processor_halt_n, 1'b1)
    repeat (20)
    begin
      rnd = xorshift(rnd);
      i_level_we = 1'b1;
      i_filter_we = rnd[20];
      i_level_data = rnd[7:0];
      i_filter_data = rnd[15:8];
      tick();
      {i_level_we, i_filter_we} = 2'b00;
      t_or = t_or | tstrobe;
      t_and = t_and & tstrobe;
      `CHK(o_attenuation, rnd[7:0])
      if (rnd[20])
      begin
        `CHK(o_lowpass_sel, rnd[11:8])
        `CHK(o_highpass_sel, rnd[15:12])
      end
    end
    `CHK(t_or, 4'hF)
    `CHK(t_and, 4'h0)
    i_converter_mode = 1'b1;
    i_sample_clock = 1'b1;
    repeat (10)
    begin
      tick();
      seen = seen | o_convert_start;
    end
    `CHK(seen, 1'b0)
    {i_converter_mode, i_sample_clock} = 2'b00;
    repeat (5) tick();
    for (int i = 0; i < 10; i++)
      conv(i == 4);
    `CHK(o_sample_valid, 1'b1)
    n = 0;
    while (exp_q.size() > 0 && n < 400)
    begin
      rnd = xorshift(rnd);
      i_sample_ready = rnd[3];
      #1;
      if (o_sample_valid === 1'b1 && i_sample_ready && exp_q.size() > 0)
      begin
        `CHK(o_sample_data, exp_q[0])
        exp_q.pop_front();
      end
      tick();
      n++;
    end
    `CHK(exp_q.size(), 0)
    give_verdict();
  end
endmodule // tb_top
bind adc_halt_control adc_halt_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC), .START_CYC(START_CYC))
  adc_halt_asserts_inst (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_halt_strobe(i_halt_strobe),
  .i_conversion_done_n(i_conversion_done_n),
  .i_level_we(i_level_we),
  .i_level_data(i_level_data),
  .i_filter_we(i_filter_we),
  .i_filter_data(i_filter_data),
  .o_convert_start(o_convert_start),
  .o_processor_halt_n(o_processor_halt_n),
  .o_hold(o_hold),
  .o_attenuation(o_attenuation),
  .o_lowpass_sel(o_lowpass_sel),
  .o_highpass_sel(o_highpass_sel),
  .o_timeout(o_timeout),
  .o_ram_refresh_timing(o_ram_refresh_timing),
  .o_row_address_select(o_row_address_select),
  .o_row_strobe_timing(o_row_strobe_timing),
  .o_column_strobe_timing(o_column_strobe_timing)
);

// file: design/adc_halt_control.sv
// sampling converter start, halt, capture and filter control
//
// Overview of operation
// [RL1] counters address a timing table giving registered memory strobes
// [RL2] samples are 16 bits, rate follows the first channel's sample clock
// [RL3] with converter mode low each sample clock edge issues a 2 us start pulse
// [RL4] halt strobe access clears halt, driving processor halt line low
// [RL5] conversion done low loads result into output data latches
// [RL6] conversion done also releases the halt line
// [RL7] halt held over 100 ms is released by a timeout
// [RL8] conversion done gates sample and hold for the whole conversion
// [RL9] attenuation follows the written level byte
// [RL10] low four filter bits select low-pass cutoff
// [RL11] high four filter bits select high-pass cutoff independently
// [RL12] timeout release keeps previously captured data
`timescale 1ns/100ps
`include "adc_halt_defines.svh"
module adc_halt_control #(
  parameter int TIMEOUT_CYC = `HALT_TIMEOUT_CYC,
  parameter int START_CYC = `START_PULSE_CYC,
  parameter int SW = `SAMPLE_W
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_sample_clock,
  input wire logic i_converter_mode,
  input wire logic i_halt_strobe,
  input wire logic i_conversion_done_n,
  input wire logic [SW-1:0] i_conv_data,
  input wire logic i_level_we,
  input wire logic [7:0] i_level_data,
  input wire logic i_filter_we,
  input wire logic [7:0] i_filter_data,
  input wire logic i_sample_ready,
  output logic o_sample_valid,
  output logic [SW-1:0] o_sample_data,
  output logic o_convert_start,
  output logic o_processor_halt_n,
  output logic o_hold,
  output logic [7:0] o_attenuation,
  output logic [3:0] o_lowpass_sel,
  output logic [3:0] o_highpass_sel,
  output logic o_timeout,
  output logic o_ram_refresh_timing,
  output logic o_row_address_select,
  output logic o_row_strobe_timing,
  output logic o_column_strobe_timing
);
  logic sc_s1_r, sc_s2_r, sc_s3_r;
  logic dn_s1_r, dn_s2_r, dn_s3_r;
  logic [SW-1:0] dat_s1_r, dat_s2_r;
  logic mode_s1_r, mode_s2_r;
  logic sc_edge, done_fall;
  logic [`ST_CNT_W-1:0] st_cnt_r, st_cnt_nxt;
  logic start_r, start_nxt;
  adc_halt_pkg::halt_state_t state_r, state_nxt;
  logic [`TO_CNT_W-1:0] to_cnt_r, to_cnt_nxt;
  logic halt_n_r, halt_n_nxt;
  logic to_r, to_nxt;
  logic [SW-1:0] latch_r, latch_nxt;
  logic hold_r, hold_nxt;
  logic [7:0] level_r, level_nxt;
  logic [7:0] filt_r, filt_nxt;
  logic fifo_in_valid, fifo_in_ready;
  logic push_r, push_nxt;
  logic [3:0] timing;
  logic [3:0] timing_r;
  logic [SW-1:0] fifo_data;
  logic fifo_valid;
  logic [SW-1:0] out_data_r;
  logic out_valid_r;
  logic [SW-1:0] out_data_nxt;
  logic out_valid_nxt;
  logic fifo_out_ready;

  // synchronisers: stage one feeds only stage two
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sc_s1_r <= 1'b0;
      sc_s2_r <= 1'b0;
      sc_s3_r <= 1'b0;
      dn_s1_r <= 1'b1;
      dn_s2_r <= 1'b1;
      dn_s3_r <= 1'b1;
      dat_s1_r <= '0;
      dat_s2_r <= '0;
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
    end
    else
    begin
      sc_s1_r <= i_sample_clock;
      sc_s2_r <= sc_s1_r;
      sc_s3_r <= sc_s2_r;
      dn_s1_r <= i_conversion_done_n;
      dn_s2_r <= dn_s1_r;
      dn_s3_r <= dn_s2_r;
      // converter data settles before done falls and is read only at done_fall
      dat_s1_r <= i_conv_data;
      dat_s2_r <= dat_s1_r;
      mode_s1_r <= i_converter_mode;
      mode_s2_r <= mode_s1_r;
    end
  end

  assign sc_edge = sc_s2_r && !sc_s3_r; // RL2
  assign done_fall = !dn_s2_r && dn_s3_r;

  // start one-shot
  always_comb
  begin
    st_cnt_nxt = st_cnt_r;
    start_nxt = start_r;
    if (sc_edge && !mode_s2_r && !start_r)
    begin
      start_nxt = 1'b1; // RL3
      st_cnt_nxt = `ST_CNT_W'(START_CYC - 1);
    end
    else if (start_r)
    begin
      if (st_cnt_r == '0)
      begin
        start_nxt = 1'b0; // RL3
      end
      else
      begin
        st_cnt_nxt = st_cnt_r - `ST_CNT_W'(1);
      end
    end
  end

  // halt sequencing, capture, timeout
  always_comb
  begin
    state_nxt = state_r;
    to_cnt_nxt = to_cnt_r;
    halt_n_nxt = halt_n_r;
    to_nxt = 1'b0;
    latch_nxt = latch_r;
    push_nxt = 1'b0;
    hold_nxt = hold_r;
    // hold rises with the start pulse so the input is frozen before conversion begins
    if (start_nxt && !start_r)
    begin
      hold_nxt = 1'b1; // RL8
    end
    if (done_fall)
    begin
      hold_nxt = 1'b0; // RL8
      latch_nxt = dat_s2_r; // RL5
      push_nxt = 1'b1;
    end
    case (state_r)
      adc_halt_pkg::ST_IDLE:
      begin
        if (i_halt_strobe && !done_fall)
        begin
          halt_n_nxt = 1'b0; // RL4
          to_cnt_nxt = '0;
          state_nxt = adc_halt_pkg::ST_HALTED;
        end
      end
      adc_halt_pkg::ST_HALTED:
      begin
        to_cnt_nxt = to_cnt_r + `TO_CNT_W'(1);
        if (done_fall)
        begin
          halt_n_nxt = 1'b1; // RL6
          state_nxt = adc_halt_pkg::ST_CAPTURE;
        end
        else if (to_cnt_r == `TO_CNT_W'(TIMEOUT_CYC - 1))
        begin
          halt_n_nxt = 1'b1; // RL7
          to_nxt = 1'b1; // RL12
          state_nxt = adc_halt_pkg::ST_IDLE;
        end
      end
      adc_halt_pkg::ST_CAPTURE:
      begin
        state_nxt = adc_halt_pkg::ST_IDLE;
        // a strobe right after a release starts the next wait
        if (i_halt_strobe && !done_fall)
        begin
          halt_n_nxt = 1'b0; // RL4
          to_cnt_nxt = '0;
          state_nxt = adc_halt_pkg::ST_HALTED;
        end
      end
      default:
      begin
        state_nxt = adc_halt_pkg::ST_IDLE;
        halt_n_nxt = 1'b1;
      end
    endcase
  end

  // filter and level control bytes
  always_comb
  begin
    level_nxt = i_level_we ? i_level_data : level_r; // RL9
    filt_nxt = i_filter_we ? i_filter_data : filt_r; // RL10 RL11
  end

  // output stage: a copy of the fifo head, popped only when the copy is taken
  always_comb
  begin
    out_data_nxt = fifo_data; // RL5
    out_valid_nxt = fifo_valid && !fifo_out_ready;
  end

  // start one-shot registers
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      st_cnt_r <= '0;
      start_r <= 1'b0;
    end
    else
    begin
      st_cnt_r <= st_cnt_nxt;
      start_r <= start_nxt;
    end
  end

  // halt, capture and timeout registers
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_r <= adc_halt_pkg::ST_IDLE;
      to_cnt_r <= '0;
      halt_n_r <= 1'b1;
      to_r <= 1'b0;
      latch_r <= '0;
      push_r <= 1'b0;
      hold_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      to_cnt_r <= to_cnt_nxt;
      halt_n_r <= halt_n_nxt;
      to_r <= to_nxt;
      latch_r <= latch_nxt;
      push_r <= push_nxt;
      hold_r <= hold_nxt;
    end
  end

  // control byte registers
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      level_r <= 8'h00;
      filt_r <= 8'h00;
    end
    else
    begin
      level_r <= level_nxt;
      filt_r <= filt_nxt;
    end
  end

  // output registers
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      timing_r <= 4'h0;
      out_data_r <= '0;
      out_valid_r <= 1'b0;
    end
    else
    begin
      timing_r <= timing; // RL1
      out_data_r <= out_data_nxt;
      out_valid_r <= out_valid_nxt;
    end
  end

  assign fifo_out_ready = out_valid_r && i_sample_ready;
  // a full fifo drops the sample, since the converter cannot be stalled
  assign fifo_in_valid = push_r && fifo_in_ready;

  sample_fifo #(
    .WIDTH(SW),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(latch_r),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_data)
  );

  memory_timing_seq #(
    .AW(`ROM_ADDR_W)
  ) u_timing (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .o_timing(timing)
  );

  assign o_sample_valid = out_valid_r;
  assign o_sample_data = out_data_r;
  assign o_convert_start = start_r;
  assign o_processor_halt_n = halt_n_r;
  assign o_hold = hold_r;
  assign o_attenuation = level_r;
  assign o_lowpass_sel = filt_r[`FILT_LP_MSB:`FILT_LP_LSB];
  assign o_highpass_sel = filt_r[`FILT_HP_MSB:`FILT_HP_LSB];
  assign o_timeout = to_r;
  assign o_ram_refresh_timing = timing_r[3];
  assign o_row_address_select = timing_r[2];
  assign o_row_strobe_timing = timing_r[1];
  assign o_column_strobe_timing = timing_r[0];
endmodule // adc_halt_control

// file: design/memory_timing_seq.sv
// counter-addressed timing table for waveform memory strobes
`timescale 1ns/100ps
`include "adc_halt_defines.svh"
module memory_timing_seq #(
  parameter int AW = `ROM_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_reset,
  output logic [3:0] o_timing
);
  logic [AW-1:0] cnt_r, cnt_nxt;
  adc_halt_pkg::timing_word_t rom_word, word_r;
  // bit3 refresh, bit2 row select, bit1 row strobe, bit0 column strobe
  always_comb
  begin
    cnt_nxt = cnt_r + AW'(1);
    case (cnt_r[3:0])
      4'h0: rom_word = 4'h0;
      4'h1: rom_word = 4'h4;
      4'h2: rom_word = 4'h6;
      4'h3: rom_word = 4'h2;
      4'h4: rom_word = 4'h3;
      4'h5: rom_word = 4'h3;
      4'h6: rom_word = 4'h2;
      4'h7: rom_word = 4'h0;
      4'h8: rom_word = 4'h8;
      4'h9: rom_word = 4'hA;
      4'hA: rom_word = 4'hA;
      4'hB: rom_word = 4'h8;
      default: rom_word = 4'h0;
    endcase
  end
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt_r <= '0;
      word_r <= 4'h0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      word_r <= rom_word; // RL1
    end
  end
  assign o_timing = word_r;
endmodule // memory_timing_seq

// file: design/sample_fifo.sv
// sample fifo with valid/ready on both sides
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;
  assign o_in_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data = mem_r[rd_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always_comb
  begin
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push)
    begin
      mem_nxt[wr_r] = i_in_data;
      wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
    end
    if (pop)
    begin
      rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
    end
    if (push && !pop)
    begin
      cnt_nxt = cnt_r + (AW+1)'(1);
    end
    else if (pop && !push)
    begin
      cnt_nxt = cnt_r - (AW+1)'(1);
    end
  end
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      for (int k = 0; k < DEPTH; k++)
      begin
        mem_r[k] <= '0;
      end
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      mem_r <= mem_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule // sample_fifo

// file: pkg/adc_halt_defines.svh
// timing and field constants for the sampling converter halt control block
`ifndef ADC_HALT_DEFINES_SVH
`define ADC_HALT_DEFINES_SVH
`define CLK_HZ 50000000
`define START_PULSE_NS 2000
`define START_PULSE_CYC ((`START_PULSE_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define HALT_TIMEOUT_MS 100
`define HALT_TIMEOUT_CYC (`HALT_TIMEOUT_MS * (`CLK_HZ / 1000))
`define SAMPLE_W 16
`define FILT_LP_LSB 0
`define FILT_LP_MSB 3
`define FILT_HP_LSB 4
`define FILT_HP_MSB 7
`define ROM_ADDR_W 4
`define ROM_DEPTH 16
`define FIFO_DEPTH 8
`define TO_CNT_W 23
`define ST_CNT_W 8
`endif

// file: pkg/adc_halt_pkg.sv
// types for the sampling converter halt control block
package adc_halt_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_HALTED = 2'b01,
    ST_CAPTURE = 2'b11
  } halt_state_t;
  typedef logic [3:0] timing_word_t;
endpackage
